/* hdl/sad_map.svh */
// sad_map.svh: address ranges of every decoder target
// assumes a 32-bit byte address; each range is inclusive
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH

`define SAD_FLASH_LO  32'h0000_0000
`define SAD_FLASH_HI  32'h0000_FFFF
`define SAD_SRAM_LO   32'h2000_0000
`define SAD_SRAM_HI   32'h2000_0FFF
`define SAD_EXT_LO    32'h6000_0000
`define SAD_EXT_HI    32'h6001_FFFF
`define SAD_GCTL_LO   32'h5000_0000
`define SAD_GCTL_HI   32'h5000_01FF
`define SAD_CLK_LO    32'h5000_0200
`define SAD_CLK_HI    32'h5000_02FF
`define SAD_IMUX_LO   32'h5000_0300
`define SAD_IMUX_HI   32'h5000_03FF
`define SAD_GPIO_LO   32'h5000_4000
`define SAD_GPIO_HI   32'h5000_7FFF
`define SAD_FCTL_LO   32'h5000_C000
`define SAD_FCTL_HI   32'h5000_FFFF
`define SAD_EBUS_LO   32'h5001_0000
`define SAD_EBUS_HI   32'h5001_03FF
`define SAD_HDIV_LO   32'h5001_4000
`define SAD_HDIV_HI   32'h5001_7FFF
`define SAD_WDOG_LO   32'h4000_4000
`define SAD_WDOG_HI   32'h4000_40FF
`define SAD_WWDG_LO   32'h4000_4100
`define SAD_WWDG_HI   32'h4000_7FFF
`define SAD_SPIA_LO   32'h4003_0000
`define SAD_SPIA_HI   32'h4003_3FFF
`define SAD_SPIB_LO   32'h4003_4000
`define SAD_SPIB_HI   32'h4003_7FFF
`define SAD_CMPA_LO   32'h400D_0000
`define SAD_CMPA_HI   32'h400D_3FFF
`define SAD_ADC_LO    32'h400E_0000
`define SAD_ADC_HI    32'h400E_FFFF
`define SAD_CMPB_LO   32'h401D_0000
`define SAD_CMPB_HI   32'h401D_3FFF
`define SAD_TICK_LO   32'hE000_E010
`define SAD_TICK_HI   32'hE000_E0FF
`define SAD_NVIC_LO   32'hE000_E100
`define SAD_NVIC_HI   32'hE000_ECFF
`define SAD_SCB_LO    32'hE000_ED00
`define SAD_SCB_HI    32'hE000_ED8F
`define SAD_RESET_TGT TGT_NONE

`endif

/* hdl/sad_pkg.sv */
// sad_pkg: types shared by the system address decoder
// assumes the map header supplies every range figure
package sad_pkg;

    typedef enum {
        TGT_FLASH, TGT_SRAM, TGT_EXT, TGT_GCTL, TGT_CLK,
        TGT_IMUX, TGT_GPIO, TGT_FCTL, TGT_EBUS, TGT_HDIV,
        TGT_WDOG, TGT_WWDG, TGT_SPIA, TGT_SPIB, TGT_CMPA,
        TGT_ADC, TGT_CMPB, TGT_TICK, TGT_NVIC, TGT_SCB,
        TGT_NONE
    } sad_tgt_t;

    localparam int SAD_NUM_TGT = int'(TGT_NONE);

    typedef enum {ERR_IDLE, ERR_FIRST, ERR_SECOND} sad_err_t;

    // address phase from the single master
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  trans;
    } sad_req_t;

    // data phase answer from each target
    typedef struct packed {
        logic [31:0] rdata;
        logic        readyout;
        logic        resp;
    } sad_resp_t;

endpackage : sad_pkg

/* hdl/sad_decoder.sv */
// sad_decoder: AHB-Lite address decoder and response mux
// assumes one master on core_clk; targets answer with
// standard readyout/resp and see hready broadcast back
//
// What this block does
// - 64 KB flash at address zero
// - 4 KB static RAM at 0x2000_0000
// - 128 KB external memory window
// - global control block on fast bus
// - clock and interrupt mux control blocks
// - general purpose port control registers
// - flash ctl, external bus ctl, divider
// - watchdog and window watchdog on slow bus
// - two serial port register blocks
// - 64 KB converter control region
// - two comparator pair register blocks
// - tick timer in private control space
// - nested interrupt controller registers
// - system control block registers
// - little endian only, lanes pass unchanged
// - full 32-bit byte address decoded
// - one master reaches all targets here
`timescale 1ns/10ps
`include "sad_map.svh"

module sad_decoder
    import sad_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // master side
    input  wire sad_req_t  mst_req,
    output logic [31:0]    hrdata,
    output logic           hready,
    output logic           hresp,
    // target side
    output logic [SAD_NUM_TGT-1:0] hsel,
    output logic           tgt_hready,
    input  wire sad_resp_t tgt_resp [SAD_NUM_TGT]
);

    // ------------------------------------------------
    // range table
    // ------------------------------------------------
    function automatic logic [31:0] tgt_lo(sad_tgt_t t);
        case (t)
            TGT_FLASH: tgt_lo = `SAD_FLASH_LO;
            TGT_SRAM:  tgt_lo = `SAD_SRAM_LO;
            TGT_EXT:   tgt_lo = `SAD_EXT_LO;
            TGT_GCTL:  tgt_lo = `SAD_GCTL_LO;
            TGT_CLK:   tgt_lo = `SAD_CLK_LO;
            TGT_IMUX:  tgt_lo = `SAD_IMUX_LO;
            TGT_GPIO:  tgt_lo = `SAD_GPIO_LO;
            TGT_FCTL:  tgt_lo = `SAD_FCTL_LO;
            TGT_EBUS:  tgt_lo = `SAD_EBUS_LO;
            TGT_HDIV:  tgt_lo = `SAD_HDIV_LO;
            TGT_WDOG:  tgt_lo = `SAD_WDOG_LO;
            TGT_WWDG:  tgt_lo = `SAD_WWDG_LO;
            TGT_SPIA:  tgt_lo = `SAD_SPIA_LO;
            TGT_SPIB:  tgt_lo = `SAD_SPIB_LO;
            TGT_CMPA:  tgt_lo = `SAD_CMPA_LO;
            TGT_ADC:   tgt_lo = `SAD_ADC_LO;
            TGT_CMPB:  tgt_lo = `SAD_CMPB_LO;
            TGT_TICK:  tgt_lo = `SAD_TICK_LO;
            TGT_NVIC:  tgt_lo = `SAD_NVIC_LO;
            TGT_SCB:   tgt_lo = `SAD_SCB_LO;
            default:   tgt_lo = `SAD_FLASH_HI;
        endcase
    endfunction : tgt_lo

    function automatic logic [31:0] tgt_hi(sad_tgt_t t);
        case (t)
            TGT_FLASH: tgt_hi = `SAD_FLASH_HI;
            TGT_SRAM:  tgt_hi = `SAD_SRAM_HI;
            TGT_EXT:   tgt_hi = `SAD_EXT_HI;
            TGT_GCTL:  tgt_hi = `SAD_GCTL_HI;
            TGT_CLK:   tgt_hi = `SAD_CLK_HI;
            TGT_IMUX:  tgt_hi = `SAD_IMUX_HI;
            TGT_GPIO:  tgt_hi = `SAD_GPIO_HI;
            TGT_FCTL:  tgt_hi = `SAD_FCTL_HI;
            TGT_EBUS:  tgt_hi = `SAD_EBUS_HI;
            TGT_HDIV:  tgt_hi = `SAD_HDIV_HI;
            TGT_WDOG:  tgt_hi = `SAD_WDOG_HI;
            TGT_WWDG:  tgt_hi = `SAD_WWDG_HI;
            TGT_SPIA:  tgt_hi = `SAD_SPIA_HI;
            TGT_SPIB:  tgt_hi = `SAD_SPIB_HI;
            TGT_CMPA:  tgt_hi = `SAD_CMPA_HI;
            TGT_ADC:   tgt_hi = `SAD_ADC_HI;
            TGT_CMPB:  tgt_hi = `SAD_CMPB_HI;
            TGT_TICK:  tgt_hi = `SAD_TICK_HI;
            TGT_NVIC:  tgt_hi = `SAD_NVIC_HI;
            TGT_SCB:   tgt_hi = `SAD_SCB_HI;
            default:   tgt_hi = `SAD_FLASH_LO;
        endcase
    endfunction : tgt_hi

    // all 32 bits compared, so no region aliases
    function automatic logic in_range(logic [31:0] a,
                                      logic [31:0] lo,
                                      logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // ranges do not overlap, so the first hit is the only one
    function automatic sad_tgt_t decode(logic [31:0] a);
        sad_tgt_t t;
        decode = TGT_NONE;
        for (int i = SAD_NUM_TGT - 1; i >= 0; i--) begin
            t = sad_tgt_t'(i);
            if (in_range(a, tgt_lo(t), tgt_hi(t))) begin
                decode = t;
            end
        end
    endfunction : decode

    function automatic logic [SAD_NUM_TGT-1:0] one_of(
        sad_tgt_t t);
        one_of = '0;
        if (t != TGT_NONE) begin
            one_of[int'(t)] = 1'b1;
        end
    endfunction : one_of

    // ------------------------------------------------
    // address phase
    // ------------------------------------------------
    sad_tgt_t addr_tgt;
    logic     take;

    assign addr_tgt = decode(mst_req.addr);
    // only NONSEQ and SEQ carry a transfer
    assign take     = hready && mst_req.trans[1];

    // unmapped addresses raise no select at all
    assign hsel = one_of(addr_tgt);
    // every target watches the one master's ready
    assign tgt_hready = hready;

    // ------------------------------------------------
    // data phase owner
    // ------------------------------------------------
    sad_tgt_t dp_tgt;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dp_tgt <= `SAD_RESET_TGT;
        end else if (hready) begin
            dp_tgt <= take ? addr_tgt : TGT_NONE;
        end
    end

    // ------------------------------------------------
    // default target: two-cycle error answer
    // ------------------------------------------------
    sad_err_t err_state;
    sad_err_t next_err_state;

    always_comb begin
        next_err_state = err_state;
        case (err_state)
            ERR_IDLE: begin
                if (take && addr_tgt == TGT_NONE) begin
                    next_err_state = ERR_FIRST;
                end
            end
            ERR_FIRST: begin
                next_err_state = ERR_SECOND;
            end
            ERR_SECOND: begin
                // hready is high here, a new request may land
                if (take && addr_tgt == TGT_NONE) begin
                    next_err_state = ERR_FIRST;
                end else begin
                    next_err_state = ERR_IDLE;
                end
            end
            default: begin
                next_err_state = ERR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_state <= ERR_IDLE;
        end else begin
            err_state <= next_err_state;
        end
    end

    // ------------------------------------------------
    // response mux
    // ------------------------------------------------
    // byte lanes pass untouched: the system is little
    // endian only and no swap path exists
    always_comb begin
        hrdata = 32'h0000_0000;
        hready = 1'b1;
        hresp  = 1'b0;
        case (err_state)
            ERR_FIRST: begin
                hready = 1'b0;
                hresp  = 1'b1;
            end
            ERR_SECOND: begin
                hready = 1'b1;
                hresp  = 1'b1;
            end
            default: begin
                if (dp_tgt != TGT_NONE) begin
                    hrdata = tgt_resp[int'(dp_tgt)].rdata;
                    hready = tgt_resp[int'(dp_tgt)].readyout;
                    hresp  = tgt_resp[int'(dp_tgt)].resp;
                end
            end
        endcase
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [31:0] a;
    assign a = mst_req.addr;

    property p_flash;
        in_range(a, `SAD_FLASH_LO, `SAD_FLASH_HI)
            |-> hsel == one_of(TGT_FLASH);
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash range not selected");

    property p_sram;
        in_range(a, `SAD_SRAM_LO, `SAD_SRAM_HI)
            |-> hsel == one_of(TGT_SRAM);
    endproperty
    a_sram: assert property (p_sram)
        else $error("sram range not selected");

    property p_ext;
        in_range(a, `SAD_EXT_LO, `SAD_EXT_HI)
            |-> hsel == one_of(TGT_EXT);
    endproperty
    a_ext: assert property (p_ext)
        else $error("external window not selected");

    property p_gctl;
        in_range(a, `SAD_GCTL_LO, `SAD_GCTL_HI)
            |-> hsel == one_of(TGT_GCTL);
    endproperty
    a_gctl: assert property (p_gctl)
        else $error("global control not selected");

    property p_clk_imux;
        (in_range(a, `SAD_CLK_LO, `SAD_CLK_HI)
            -> hsel == one_of(TGT_CLK)) &&
        (in_range(a, `SAD_IMUX_LO, `SAD_IMUX_HI)
            -> hsel == one_of(TGT_IMUX));
    endproperty
    a_clk_imux: assert property (p_clk_imux)
        else $error("clock or irq mux not selected");

    property p_gpio;
        in_range(a, `SAD_GPIO_LO, `SAD_GPIO_HI)
            |-> hsel == one_of(TGT_GPIO);
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("port control not selected");

    property p_fast_misc;
        (in_range(a, `SAD_FCTL_LO, `SAD_FCTL_HI)
            -> hsel == one_of(TGT_FCTL)) &&
        (in_range(a, `SAD_EBUS_LO, `SAD_EBUS_HI)
            -> hsel == one_of(TGT_EBUS)) &&
        (in_range(a, `SAD_HDIV_LO, `SAD_HDIV_HI)
            -> hsel == one_of(TGT_HDIV));
    endproperty
    a_fast_misc: assert property (p_fast_misc)
        else $error("flash ctl, bus ctl or divider missed");

    property p_wdog;
        (in_range(a, `SAD_WDOG_LO, `SAD_WDOG_HI)
            -> hsel == one_of(TGT_WDOG)) &&
        (in_range(a, `SAD_WWDG_LO, `SAD_WWDG_HI)
            -> hsel == one_of(TGT_WWDG));
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog block not selected");

    property p_spi;
        (in_range(a, `SAD_SPIA_LO, `SAD_SPIA_HI)
            -> hsel == one_of(TGT_SPIA)) &&
        (in_range(a, `SAD_SPIB_LO, `SAD_SPIB_HI)
            -> hsel == one_of(TGT_SPIB));
    endproperty
    a_spi: assert property (p_spi)
        else $error("serial port not selected");

    property p_adc;
        in_range(a, `SAD_ADC_LO, `SAD_ADC_HI)
            |-> hsel == one_of(TGT_ADC);
    endproperty
    a_adc: assert property (p_adc)
        else $error("converter not selected");

    property p_cmp;
        (in_range(a, `SAD_CMPA_LO, `SAD_CMPA_HI)
            -> hsel == one_of(TGT_CMPA)) &&
        (in_range(a, `SAD_CMPB_LO, `SAD_CMPB_HI)
            -> hsel == one_of(TGT_CMPB));
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("comparator pair not selected");

    property p_tick;
        in_range(a, `SAD_TICK_LO, `SAD_TICK_HI)
            |-> hsel == one_of(TGT_TICK);
    endproperty
    a_tick: assert property (p_tick)
        else $error("tick timer not selected");

    property p_nvic;
        in_range(a, `SAD_NVIC_LO, `SAD_NVIC_HI)
            |-> hsel == one_of(TGT_NVIC);
    endproperty
    a_nvic: assert property (p_nvic)
        else $error("interrupt controller not selected");

    property p_scb;
        in_range(a, `SAD_SCB_LO, `SAD_SCB_HI)
            |-> hsel == one_of(TGT_SCB);
    endproperty
    a_scb: assert property (p_scb)
        else $error("control block not selected");

    // a taken flash read returns its data on the lanes as is
    property p_lanes;
        take && addr_tgt == TGT_FLASH ##1 hready
            |-> hrdata == tgt_resp[int'(TGT_FLASH)].rdata;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("read data lanes altered");

    // one bit apart in the top byte must not alias
    property p_full_addr;
        a[31:24] == 8'h10 |-> hsel == '0;
    endproperty
    a_full_addr: assert property (p_full_addr)
        else $error("high address bits ignored");

    property p_one_master;
        $onehot0(hsel) && tgt_hready == hready;
    endproperty
    a_one_master: assert property (p_one_master)
        else $error("select not one-hot or ready split");

    sequence s_bad_req;
        take && addr_tgt == TGT_NONE;
    endsequence

    sequence s_err_ans;
        (!hready && hresp) ##1 (hready && hresp);
    endsequence

    property p_error;
        s_bad_req |=> s_err_ans;
    endproperty
    a_error: assert property (p_error)
        else $error("unmapped access not answered error");

    property p_no_sel_bad;
        addr_tgt == TGT_NONE |-> hsel == '0;
    endproperty
    a_no_sel_bad: assert property (p_no_sel_bad)
        else $error("unmapped address raised a select");

endmodule : sad_decoder

/* verification/sad_mst_model.sv */
// sad_mst_model: behavioural single bus master for the decoder
// assumes a free running core_clk; drives 1 ns after falling edge
`timescale 1ns/10ps

module sad_mst_model
    import sad_pkg::*;
(
    // clock
    input  wire logic        core_clk,
    // bus
    output sad_req_t         mst_req,
    input  wire logic [31:0] hrdata,
    input  wire logic        hready,
    input  wire logic        hresp
);
    initial begin
        mst_req = '0;
    end

    // ------------------------------------------------------------
    // one transfer; chain issues it in the caller's own cycle
    // ------------------------------------------------------------
    // the request is left standing when a data phase ends without waits, so the
    // caller must follow with idle() or a chained xfer at once
    task automatic xfer(
        input  logic [31:0] addr,
        input  logic [1:0]  trans,
        input  bit          chain,
        output logic [31:0] data,
        output logic        err,
        output int          waits
    );
        int n;
        n = 0;
        if (!chain) begin
            @(negedge core_clk);
            #1;
        end
        mst_req.addr  = addr;
        mst_req.trans = trans;
        while (hready !== 1'b1 && n < 64) begin
            @(negedge core_clk);
            #1;
            n++;
        end
        waits = (n >= 64) ? 64 : 0;
        @(negedge core_clk);
        #1;
        while (hready !== 1'b1 && waits < 64) begin
            // drop the request so a stalled phase is not taken twice
            if (waits == 0) begin
                mst_req.trans = 2'b00;
            end
            @(negedge core_clk);
            #1;
            waits++;
        end
        data = hrdata;
        err  = hresp;
    endtask : xfer

    task automatic idle();
        mst_req.trans = 2'b00;
    endtask : idle
endmodule : sad_mst_model

/* verification/sad_decoder_tb.sv */
// sad_decoder_tb: self-checking bench for the address decoder
// assumes sad_mst_model as master and ideal targets in this file
`timescale 1ns/10ps

module sad_decoder_tb
    import sad_pkg::*;
;
    logic                   core_clk;
    logic                   rst;
    sad_req_t               mst_req;
    logic [31:0]            hrdata;
    logic                   hready;
    logic                   hresp;
    logic [SAD_NUM_TGT-1:0] hsel;
    logic                   tgt_hready;
    sad_resp_t              tgt_resp [SAD_NUM_TGT];
    logic                   stall;
    int                     n_fail;
    int                     samples_checked;

    localparam logic [31:0] LO [SAD_NUM_TGT] = '{
        32'h0000_0000, 32'h2000_0000, 32'h6000_0000, 32'h5000_0000,
        32'h5000_0200, 32'h5000_0300, 32'h5000_4000, 32'h5000_C000,
        32'h5001_0000, 32'h5001_4000, 32'h4000_4000, 32'h4000_4100,
        32'h4003_0000, 32'h4003_4000, 32'h400D_0000, 32'h400E_0000,
        32'h401D_0000, 32'hE000_E010, 32'hE000_E100, 32'hE000_ED00};
    localparam logic [31:0] HI [SAD_NUM_TGT] = '{
        32'h0000_FFFF, 32'h2000_0FFF, 32'h6001_FFFF, 32'h5000_01FF,
        32'h5000_02FF, 32'h5000_03FF, 32'h5000_7FFF, 32'h5000_FFFF,
        32'h5001_03FF, 32'h5001_7FFF, 32'h4000_40FF, 32'h4000_7FFF,
        32'h4003_3FFF, 32'h4003_7FFF, 32'h400D_3FFF, 32'h400E_FFFF,
        32'h401D_3FFF, 32'hE000_E0FF, 32'hE000_ECFF, 32'hE000_ED8F};
    // just outside most ranges; the one below the tick timer is not decoded
    localparam logic [31:0] BAD [12] = '{
        32'h0001_0000, 32'h2000_1000, 32'h6002_0000, 32'h5000_0400,
        32'h5000_8000, 32'h5001_8000, 32'h4000_3FFF, 32'h4001_0000,
        32'h401D_4000, 32'hE000_E00F, 32'hE000_ED90, 32'hFFFF_FFFF};

    // ------------------------------------------------------------
    // clock, reset, targets
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rst      = 1'b1;
        stall    = 1'b0;
        n_fail   = 0;
        samples_checked = 0;
    end

    always #5 core_clk = ~core_clk;

    // distinct byte per lane shows any lane swap, except for targets 2 to 4 where the low byte repeats another lane
    always_comb begin
        for (int i = 0; i < SAD_NUM_TGT; i++) begin
            tgt_resp[i].rdata    = 32'h0403_0200 | 32'(i);
            tgt_resp[i].readyout = !stall;
            tgt_resp[i].resp     = 1'b0;
        end
    end

    sad_decoder dut_u (
        .core_clk   (core_clk),
        .rst        (rst),
        .mst_req    (mst_req),
        .hrdata     (hrdata),
        .hready     (hready),
        .hresp      (hresp),
        .hsel       (hsel),
        .tgt_hready (tgt_hready),
        .tgt_resp   (tgt_resp)
    );

    sad_mst_model mst_u (
        .core_clk (core_clk),
        .mst_req  (mst_req),
        .hrdata   (hrdata),
        .hready   (hready),
        .hresp    (hresp)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [31:0] a, input logic [1:0] t,
                      input bit c, output logic [31:0] d,
                      output logic e, output int w);
        mst_u.xfer(a, t, c, d, e, w);
        if (w >= 64) begin
            n_fail++;
            $display("Error handshake expected ready seen timeout");
            print_verdict();
        end
    endtask : rd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_walk();
        repeat (6) @(negedge core_clk);
        chk("rst_hready", 1, 32'(hready));
        chk("rst_hresp", 0, 32'(hresp));
        chk("rst_hrdata", 0, hrdata);
    endtask : reset_walk

    task automatic map_walk(input int first, input int last);
        logic [31:0] d;
        logic        e;
        int          w;
        for (int i = first; i < last; i++) begin
            for (int j = 0; j < 2; j++) begin
                rd(j ? HI[i] : LO[i], 2'b10, 1'b0, d, e, w);
                mst_u.idle();
                chk("hsel", 32'h1 << i, 32'(hsel));
                chk("hrdata", 32'h0403_0200 | 32'(i), d);
                chk("hresp", 0, 32'(e));
                chk("waits", 0, 32'(w));
            end
        end
    endtask : map_walk

    task automatic unmapped_walk();
        logic [31:0] d;
        logic        e;
        int          w;
        for (int k = 0; k < 12; k++) begin
            rd(BAD[k], 2'b10, 1'b0, d, e, w);
            mst_u.idle();
            chk("bad_hsel", 0, 32'(hsel));
            chk("bad_waits", 1, 32'(w));
            chk("bad_hresp", 1, 32'(e));
            chk("bad_hrdata", 0, d);
            @(negedge core_clk);
            #1;
            chk("post_hresp", 0, 32'(hresp));
            chk("post_hready", 1, 32'(hready));
        end
    endtask : unmapped_walk

    task automatic trans_walk();
        logic [31:0] d;
        logic        e;
        int          w;
        for (int t = 0; t < 4; t++) begin
            rd(32'h1000_0000, 2'(t), 1'b0, d, e, w);
            mst_u.idle();
            chk("trans_err", 32'(t >> 1), 32'(e));
            chk("trans_waits", 32'(t >> 1), 32'(w));
        end
    endtask : trans_walk

    task automatic stall_walk();
        logic [31:0] d;
        logic        e;
        int          w;
        @(negedge core_clk);
        stall = 1'b1;
        fork
            rd(32'h2000_0010, 2'b10, 1'b0, d, e, w);
            begin
                repeat (2) @(negedge core_clk);
                #2;
                chk("tgt_hready", 0, 32'(tgt_hready));
            end
            begin
                repeat (4) @(negedge core_clk);
                stall = 1'b0;
            end
        join
        mst_u.idle();
        chk("stall_waits", 2, 32'(w));
        chk("stall_data", 32'h0403_0201, d);
    endtask : stall_walk

    task automatic chain_walk();
        logic [31:0] d;
        logic        e;
        int          w;
        rd(32'h1000_0000, 2'b10, 1'b0, d, e, w);
        chk("chain_err", 1, 32'(e));
        rd(32'h0000_0100, 2'b10, 1'b1, d, e, w);
        chk("chain_flash", 32'h0403_0200, d);
        rd(32'h2000_0FFC, 2'b11, 1'b1, d, e, w);
        mst_u.idle();
        chk("chain_sram", 32'h0403_0201, d);
        chk("chain_resp", 0, 32'(e));
    endtask : chain_walk

    task automatic reset_mid_walk();
        logic [31:0] d;
        logic        e;
        int          w;
        // reset lands in the first error cycle and cancels the answer
        fork
            rd(32'h1000_0000, 2'b10, 1'b0, d, e, w);
            begin
                repeat (2) @(negedge core_clk);
                rst = 1'b1;
                @(negedge core_clk);
                rst = 1'b0;
            end
        join
        chk("mid_rst_hresp", 0, 32'(e));
        chk("mid_rst_waits", 1, 32'(w));
        // the first edge after release already takes a request
        rd(32'h0000_0004, 2'b10, 1'b1, d, e, w);
        mst_u.idle();
        chk("mid_rst_data", 32'h0403_0200, d);
        chk("mid_rst_resp", 0, 32'(e));
    endtask : reset_mid_walk

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_walk();
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        map_walk(0, 3);
        map_walk(3, 10);
        map_walk(10, 17);
        map_walk(17, 20);
        unmapped_walk();
        trans_walk();
        stall_walk();
        chain_walk();
        reset_mid_walk();
        print_verdict();
    end

    // cuts a hang short, far past the end of a normal run
    initial begin
        #200000;
        n_fail++;
        $display("Error run expected end seen timeout");
        print_verdict();
    end
endmodule : sad_decoder_tb
